// ===== pkg/sadc_fifo_if.sv
// Valid/ready carrier between the control logic and the result queue
interface sadc_fifo_if #(parameter int W = 13);
	logic in_valid;
	logic in_ready;
	logic [W-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [W-1:0] out_data;
	modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
	modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

// ===== pkg/sadc_pkg.sv
// Shared constants, types and helpers of the serial converter control port
package sadc_pkg;
	// ********************************************************
	// Register map, byte addresses on the Avalon slave
	// ********************************************************
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_CODE = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam logic [3:0] REG_RESULT = 4'hc;
	localparam int CTRL_SRC_BIT = 0;
	localparam int CTRL_EN_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h2;
	localparam logic [9:0] CODE_RST = 10'h000;

	// ********************************************************
	// Configuration word, first bit shifted in lands in bit 7
	// ********************************************************
	localparam int CFG_SGL = 7;
	localparam int CFG_ODD = 6;
	localparam int CFG_UNI = 3;
	localparam int CFG_MSBF = 2;
	localparam int CFG_WL_LO = 0;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [1:0] WL_8 = 2'h0;
	localparam logic [1:0] WL_10 = 2'h1;
	localparam logic [1:0] WL_12 = 2'h2;
	localparam logic [1:0] WL_16 = 2'h3;

	// ********************************************************
	// Widths and counts
	// ********************************************************
	localparam int CFG_BITS = 8;
	localparam int RES_BITS = 10;
	localparam int OUT_BITS = 16;
	localparam int ACLK_WAIT = 2;
	localparam int CONV_ACLK = 44;
	localparam int SAMPLE_SCLK = 5;
	localparam int SAMPLE_START = 4;
	localparam int FIFO_DEPTH = 8;
	localparam int ENT_MSBF = 10;
	localparam int ENT_WL_LO = 11;
	localparam int ENT_W = 13;

	// ********************************************************
	// State types
	// ********************************************************
	typedef enum logic [3:0] {
		LS_IDLE = 4'h1,
		LS_WAIT = 4'h2,
		LS_SHIFT = 4'h4,
		LS_END = 4'h8
	} sadc_link_t;
	typedef enum logic [2:0] {
		CV_IDLE = 3'h1,
		CV_RUN = 3'h2,
		CV_PUSH = 3'h4
	} sadc_conv_t;

	// Word length code to number of shift clocks
	function automatic logic [4:0] word_len(input logic [1:0] wl);
		logic [4:0] n;
		n = 5'h08;
		case (wl)
			WL_10: n = 5'h0a;
			WL_12: n = 5'h0c;
			WL_16: n = 5'h10;
			default: n = 5'h08;
		endcase
		return n;
	endfunction

	// Queue entry to outgoing shift word, bit 15 goes first
	function automatic logic [15:0] fmt_word(input logic [12:0] e);
		logic [9:0] v;
		v = e[9:0];
		if (!e[ENT_MSBF])
		begin
			for (int i = 0; i < RES_BITS; i++)
			begin
				v[i] = e[RES_BITS - 1 - i];
			end
		end
		return {v, 6'h00};
	endfunction
endpackage

// ===== rtl/sadc_ctrl.sv
// Control and serial exchange logic of the eight-input converter port
//
// Decided for this implementation: the Avalon-MM register port and the register addresses.

module sadc_ctrl (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic cs_n_i,
	input wire logic sclk_i,
	input wire logic din_i,
	input wire logic aclk_i,
	output logic dout_o,
	output logic dout_oe_n_o,
	input wire logic [9:0] adc_code_i,
	output logic [2:0] mux_pos_o,
	output logic [2:0] mux_neg_o,
	output logic mux_neg_com_o,
	output logic sample_o
);
	// ********************************************************
	// Pin synchronisers and edge finding
	// ********************************************************
	logic [3:0] pin_s;
	logic [3:0] pin_d_q;
	logic cs_n_s;
	logic din_s;
	logic sclk_s;
	logic aclk_s;
	logic cs_fall;
	logic sclk_rise;
	logic sclk_fall;
	logic aclk_rise;
	logic aclk_fall;

	sadc_sync #(
		.W(4),
		.INIT(4'h1)
	) sadc_sync_inst (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.d_i({aclk_i, sclk_i, din_i, cs_n_i}),
		.q_o(pin_s)
	);

	assign cs_n_s = pin_s[0];
	assign din_s = pin_s[1];
	assign sclk_s = pin_s[2];
	assign aclk_s = pin_s[3];

	// Delayed copy of synchronised pins for edges
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			pin_d_q <= 4'h1;
		else
			pin_d_q <= pin_s;
	end

	assign cs_fall = pin_d_q[0] & ~cs_n_s;
	assign sclk_rise = ~pin_d_q[2] & sclk_s;
	assign sclk_fall = pin_d_q[2] & ~sclk_s;
	assign aclk_rise = ~pin_d_q[3] & aclk_s;
	assign aclk_fall = pin_d_q[3] & ~aclk_s;

	// ********************************************************
	// Registers and result queue
	// ********************************************************
	logic [1:0] ctrl_q;
	logic [9:0] code_q;
	logic ack_q;
	logic [31:0] rdata_q;
	sadc_pkg::sadc_link_t lst_q;
	sadc_pkg::sadc_conv_t cst_q;
	logic [1:0] afc_q;
	logic [4:0] rise_cnt_q;
	logic [7:0] cfg_sr_q;
	logic [7:0] cfg_q;
	logic [15:0] out_sr_q;
	logic [1:0] olen_q;
	logic start_q;
	logic [5:0] conv_cnt_q;
	logic [9:0] raw_q;
	logic [9:0] result_q;
	logic [2:0] samp_cnt_q;
	logic [3:0] addr4;
	logic frame_go;
	logic last_rise;

	sadc_fifo_if #(.W(sadc_pkg::ENT_W)) fq ();

	sadc_fifo #(
		.W(sadc_pkg::ENT_W),
		.DEPTH(sadc_pkg::FIFO_DEPTH)
	) sadc_fifo_inst (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.q(fq)
	);

	// ********************************************************
	// Avalon-MM slave, one wait state per access
	// ********************************************************
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
	assign avs_readdata_o = rdata_q;

	// Ack pulses once per request so back-to-back accesses each wait
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			ack_q <= 1'b0;
		else
			ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
	end

	// Read data prepared in the wait cycle
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			rdata_q <= 32'h0000_0000;
		else if (avs_read_i & ~ack_q)
		begin
			if (avs_address_i == sadc_pkg::REG_CTRL)
				rdata_q <= {30'h0000_0000, ctrl_q};
			else if (avs_address_i == sadc_pkg::REG_CODE)
				rdata_q <= {22'h00_0000, code_q};
			else if (avs_address_i == sadc_pkg::REG_STATUS)
				rdata_q <= {16'h0000, cfg_q, 4'h0, fq.in_ready, fq.out_valid,
					~lst_q[0], ~cst_q[0]};
			else if (avs_address_i == sadc_pkg::REG_RESULT)
				rdata_q <= {22'h00_0000, result_q};
			else
				rdata_q <= 32'h0000_0000;
		end
	end

	// Writes land on the edge after waitrequest drops, where the master samples it low
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			ctrl_q <= sadc_pkg::CTRL_RST;
			code_q <= sadc_pkg::CODE_RST;
		end
		else if (avs_write_i & ack_q)
		begin
			if (avs_address_i == sadc_pkg::REG_CTRL)
			begin
				if (avs_byteenable_i[0])
					ctrl_q <= avs_writedata_i[1:0];
			end
			else if (avs_address_i == sadc_pkg::REG_CODE)
			begin
				if (avs_byteenable_i[0])
					code_q[7:0] <= avs_writedata_i[7:0];
				if (avs_byteenable_i[1])
					code_q[9:8] <= avs_writedata_i[9:8];
			end
		end
	end

	// ********************************************************
	// Link state machine
	// ********************************************************
	assign frame_go = (lst_q == sadc_pkg::LS_WAIT) & ~cs_n_s & aclk_fall
		& (afc_q == 2'(sadc_pkg::ACLK_WAIT - 1));
	assign last_rise = (lst_q == sadc_pkg::LS_SHIFT) & ~cs_n_s & sclk_rise
		& (rise_cnt_q == sadc_pkg::word_len(olen_q) - 5'h01);

	// Select high aborts any frame at once
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			lst_q <= sadc_pkg::LS_IDLE;
		else
		begin
			case (lst_q)
				sadc_pkg::LS_IDLE:
					if (cs_fall & ctrl_q[sadc_pkg::CTRL_EN_BIT])
						lst_q <= sadc_pkg::LS_WAIT;
				sadc_pkg::LS_WAIT:
					if (cs_n_s)
						lst_q <= sadc_pkg::LS_IDLE;
					else if (frame_go)
						lst_q <= sadc_pkg::LS_SHIFT;
				sadc_pkg::LS_SHIFT:
					if (cs_n_s)
						lst_q <= sadc_pkg::LS_IDLE;
					else if (last_rise)
						lst_q <= sadc_pkg::LS_END;
				sadc_pkg::LS_END:
					if (cs_n_s)
						lst_q <= sadc_pkg::LS_IDLE;
				default:
					lst_q <= sadc_pkg::LS_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			afc_q <= 2'h0;
		else if (lst_q != sadc_pkg::LS_WAIT)
			afc_q <= 2'h0;
		else if (aclk_fall)
			afc_q <= afc_q + 2'h1;
	end

	// Rising shift clock edges within the frame
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			rise_cnt_q <= 5'h00;
		else if (lst_q != sadc_pkg::LS_SHIFT)
			rise_cnt_q <= (lst_q == sadc_pkg::LS_END) ? rise_cnt_q : 5'h00;
		else if (sclk_rise)
			rise_cnt_q <= rise_cnt_q + 5'h01;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			cfg_sr_q <= sadc_pkg::CFG_RST;
		else if (cs_fall)
			cfg_sr_q <= sadc_pkg::CFG_RST;
		else if ((lst_q == sadc_pkg::LS_SHIFT) & sclk_rise
			& (rise_cnt_q < 5'(sadc_pkg::CFG_BITS)))
			cfg_sr_q <= {cfg_sr_q[6:0], din_s};
	end

	// ********************************************************
	// Result output shifter
	// ********************************************************
	// pop previous frame's result
	assign fq.out_ready = frame_go;

	// order baked into the word
	// Falls before the first rise are skipped for an idle-high shift clock
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			out_sr_q <= 16'h0000;
			olen_q <= sadc_pkg::WL_10;
		end
		else if (frame_go)
		begin
			out_sr_q <= fq.out_valid ? sadc_pkg::fmt_word(fq.out_data) : 16'h0000;
			olen_q <= fq.out_valid ? fq.out_data[12:11] : sadc_pkg::WL_10;
		end
		else if (lst_q == sadc_pkg::LS_IDLE)
			out_sr_q <= 16'h0000;
		else if (sclk_fall & (rise_cnt_q != 5'h00))
			out_sr_q <= {out_sr_q[14:0], 1'b0};
	end

	assign dout_o = out_sr_q[15];
	assign dout_oe_n_o = ~(lst_q[2] | lst_q[3]);

	// ********************************************************
	// Sampling window and input mux
	// ********************************************************
	assign addr4 = {cfg_sr_q[2:0], din_s};

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			sample_o <= 1'b0;
			samp_cnt_q <= 3'h0;
			mux_pos_o <= 3'h0;
			mux_neg_o <= 3'h1;
			mux_neg_com_o <= 1'b0;
		end
		else if (lst_q == sadc_pkg::LS_IDLE)
			sample_o <= 1'b0;
		else if (sclk_rise & (lst_q == sadc_pkg::LS_SHIFT)
			& (rise_cnt_q == 5'(sadc_pkg::SAMPLE_START - 1)))
		begin
			sample_o <= 1'b1;
			samp_cnt_q <= 3'h0;
			mux_pos_o <= {addr4[1:0], addr4[2]};
			mux_neg_o <= {addr4[1:0], ~addr4[2]};
			mux_neg_com_o <= addr4[3];
		end
		else if (sample_o & sclk_rise)
		begin
			samp_cnt_q <= samp_cnt_q + 3'h1;
			if (samp_cnt_q == 3'(sadc_pkg::SAMPLE_SCLK - 1))
				sample_o <= 1'b0;
		end
	end

	// ********************************************************
	// Conversion sequencer
	// ********************************************************
	// Start one cycle after the last rise so the config byte is whole
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			start_q <= 1'b0;
		else
			start_q <= last_rise;
	end

	// host keeps spacing, late start dropped
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			cst_q <= sadc_pkg::CV_IDLE;
			cfg_q <= sadc_pkg::CFG_RST;
			conv_cnt_q <= 6'h00;
			raw_q <= 10'h000;
		end
		else
		begin
			case (cst_q)
				sadc_pkg::CV_IDLE:
					if (start_q)
					begin
						cfg_q <= cfg_sr_q;
						conv_cnt_q <= 6'h00;
						cst_q <= sadc_pkg::CV_RUN;
					end
				sadc_pkg::CV_RUN:
					if (aclk_rise)
					begin
						if (conv_cnt_q == 6'(sadc_pkg::CONV_ACLK - 1))
						begin
							conv_cnt_q <= 6'h00;
							raw_q <= ctrl_q[sadc_pkg::CTRL_SRC_BIT] ? code_q : adc_code_i;
							cst_q <= sadc_pkg::CV_PUSH;
						end
						else
							conv_cnt_q <= conv_cnt_q + 6'h01;
					end
				sadc_pkg::CV_PUSH:
					// Full queue stalls here until the host drains it
					if (fq.in_ready)
						cst_q <= sadc_pkg::CV_IDLE;
				default:
					cst_q <= sadc_pkg::CV_IDLE;
			endcase
		end
	end

	// flip sign bit for two's complement
	assign fq.in_valid = (cst_q == sadc_pkg::CV_PUSH);
	assign fq.in_data = {cfg_q[1:0], cfg_q[sadc_pkg::CFG_MSBF],
		cfg_q[sadc_pkg::CFG_UNI] ? raw_q : {~raw_q[9], raw_q[8:0]}};

	// Last completed result for software
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			result_q <= 10'h000;
		else if (fq.in_valid & fq.in_ready)
			result_q <= fq.in_data[9:0];
	end

	// ********************************************************
	// Checks
	// ********************************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	AST_HIZ_IDLE: assert property (cs_n_s |=> dout_oe_n_o)
		else $error("output driven with select high");
	AST_WAIT_TWO: assert property ((lst_q == sadc_pkg::LS_WAIT && !cs_n_s && aclk_fall
		&& afc_q == 2'h0) |=> lst_q == sadc_pkg::LS_WAIT && dout_oe_n_o)
		else $error("responded before second conversion clock fall");
	AST_FIRST_BIT: assert property (frame_go |=> !dout_oe_n_o
		&& dout_o == $past(fq.out_valid && (fq.out_data[sadc_pkg::ENT_MSBF]
		? fq.out_data[9] : fq.out_data[0])))
		else $error("first bit not presented after two falls");
	AST_CFG_HOLD: assert property ((lst_q == sadc_pkg::LS_SHIFT
		&& rise_cnt_q >= 5'h08 && !cs_fall) |=> $stable(cfg_sr_q))
		else $error("config taken beyond eighth bit");
	AST_WORD_LEN: assert property ($rose(lst_q == sadc_pkg::LS_END)
		|-> rise_cnt_q == sadc_pkg::word_len(olen_q))
		else $error("exchange length differs from word length");
	AST_SAMPLE_WIN: assert property ($rose(sample_o) |-> rise_cnt_q == 5'h04
		&& samp_cnt_q == 3'h0)
		else $error("sample window opened at wrong edge");
	AST_CONV_LEN: assert property ($rose(cst_q == sadc_pkg::CV_PUSH)
		|-> $past(conv_cnt_q) == 6'h2b && $past(aclk_rise))
		else $error("conversion length not 44 clocks");
	AST_BIPOLAR: assert property ((fq.in_valid && !cfg_q[sadc_pkg::CFG_UNI])
		|-> fq.in_data[9] != raw_q[9] && fq.in_data[8:0] == raw_q[8:0])
		else $error("bipolar result not two's complement");
	AST_PREV_RES: assert property ((fq.out_valid && fq.out_ready)
		|=> out_sr_q == sadc_pkg::fmt_word($past(fq.out_data)))
		else $error("frame did not load queued result");
	AST_START_ONE: assert property ($rose(cst_q == sadc_pkg::CV_RUN)
		|-> $past(start_q) && cfg_q == $past(cfg_sr_q))
		else $error("conversion started without a finished exchange");
endmodule

// ===== rtl/sadc_fifo.sv
// Result queue with registered head word
module sadc_fifo #(
	parameter int W = 13,
	parameter int DEPTH = 8
)(
	input wire logic clk_i,
	input wire logic rst_n_i,
	sadc_fifo_if.fifo q
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wptr_q;
	logic [AW-1:0] rptr_q;
	logic [AW:0] cnt_q;
	logic [W-1:0] data_q;
	logic valid_q;
	logic push;
	logic load;

	// Full only counts the array; the head register adds one slot
	assign q.in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign push = q.in_valid & q.in_ready;
	assign load = (!valid_q | q.out_ready) & (cnt_q != '0);
	assign q.out_valid = valid_q;
	assign q.out_data = data_q;

	// Storage array, no reset needed
	always_ff @(posedge clk_i)
	begin
		if (push)
		begin
			mem_q[wptr_q] <= q.in_data;
		end
	end

	// Pointers and fill count
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			wptr_q <= '0;
			rptr_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wptr_q <= wptr_q + AW'(1);
			if (load)
				rptr_q <= rptr_q + AW'(1);
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(load);
		end
	end

	// Head register gives registered read data
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			valid_q <= 1'b0;
			data_q <= '0;
		end
		else if (load)
		begin
			valid_q <= 1'b1;
			data_q <= mem_q[rptr_q];
		end
		else if (q.out_ready)
		begin
			valid_q <= 1'b0;
		end
	end
endmodule

// ===== rtl/sadc_sync.sv
// Two flip-flop synchroniser for pin inputs
module sadc_sync #(
	parameter int W = 4,
	parameter logic [W-1:0] INIT = '0
)(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;

	// First stage feeds only the second
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			s1_q <= INIT;
			s2_q <= INIT;
		end
		else
		begin
			s1_q <= d_i;
			s2_q <= s1_q;
		end
	end

	assign q_o = s2_q;
endmodule

// ===== tb/sadc_ctrl_test.sv
// Self-checking bench of the converter control port
module sadc_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n;
	logic aclk;
	logic [3:0] address;
	logic rd;
	logic wr;
	logic [31:0] wdata;
	logic [3:0] byteen;
	logic [31:0] rdata;
	logic wait_req;
	logic cs_n;
	logic sclk;
	logic din;
	logic dout;
	logic dout_oe_n;
	logic [9:0] code;
	logic [2:0] mux_pos;
	logic [2:0] mux_neg;
	logic mux_com;
	logic sample;
	wire dout_line;
	int n_mismatch = 0;
	int comparisons = 0;
	logic [7:0] cfg_tab [6] = '{8'hbc, 8'h51, 8'hea, 8'h07, 8'hfd, 8'h00};
	logic [9:0] code_tab [6] = '{10'h3c5, 10'h0f1, 10'h2aa, 10'h155, 10'h2a5, 10'h000};

	// System clock 200 MHz; conversion clock 10 MHz, unrelated in phase
	always #2.5 clk = ~clk;
	always #50 aclk = ~aclk;
	// Output line floats whenever the port lets go
	assign dout_line = dout_oe_n ? 1'bz : dout;

	sadc_ctrl sadc_ctrl_inst (.clk_i(clk), .rst_n_i(rst_n), .avs_address_i(address),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
		.avs_byteenable_i(byteen), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
		.cs_n_i(cs_n), .sclk_i(sclk), .din_i(din), .aclk_i(aclk), .dout_o(dout),
		.dout_oe_n_o(dout_oe_n), .adc_code_i(code), .mux_pos_o(mux_pos),
		.mux_neg_o(mux_neg), .mux_neg_com_o(mux_com), .sample_o(sample));
	sadc_host_model sadc_host_model_inst (.clk_i(clk), .dout_i(dout_line),
		.dout_oe_n_i(dout_oe_n), .sample_i(sample), .cs_n_o(cs_n), .sclk_o(sclk),
		.din_o(din));

	// ********************************************************
	// Shared tasks
	// ********************************************************
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Avalon access; request held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int t;
		t = 0;
		@(posedge clk);
		address <= a;
		rd <= !w;
		wr <= w;
		wdata <= d;
		byteen <= 4'hf;
		do
		begin
			@(posedge clk);
			t++;
		end
		while (wait_req !== 1'b0 && t < 20);
		q = rdata;
		// A dead handshake ends the run as a failure
		if (t >= 20)
		begin
			n_mismatch++;
			results();
		end
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	// Expected serial word: ordered result, zero fill, top n bits
	function automatic logic [15:0] expect_word(logic [9:0] v, logic [7:0] c, int n);
		logic [15:0] s;
		s = 16'h0000;
		for (int i = 0; i < 10; i++)
			s[15 - i] = c[2] ? v[9 - i] : v[i];
		return s >> (16 - n);
	endfunction

	function automatic int wlen(logic [7:0] c);
		return (c[1:0] == 2'h3) ? 16 : 8 + 2 * int'(c[1:0]);
	endfunction

	task automatic results();
		$display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ********************************************************
	// Main sequence
	// ********************************************************
	initial
	begin
		logic [31:0] q;
		logic [15:0] rx;
		logic [9:0] v;
		logic [7:0] pc;
		int lat;
		int samp;
		int n;
		rst_n = 1'b0;
		aclk = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		address = 4'h0;
		wdata = 32'h0;
		byteen = 4'h0;
		code = 10'h000;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		check("oe_n idle", dout_oe_n, 32'h1);
		bus(1'b0, sadc_pkg::REG_CTRL, 32'h0, q);
		check("ctrl reset", q, 32'h2);
		bus(1'b0, sadc_pkg::REG_CODE, 32'h0, q);
		check("code reset", q, 32'h0);
		bus(1'b0, 4'h1, 32'h0, q);
		check("unmapped", q, 32'h0);
		pc = 8'h00;
		v = 10'h000;
		// Modes, orders and word lengths in turn, each answered one frame later
		for (int k = 0; k < 6; k++)
		begin
			if (k == 4)
			begin
				bus(1'b1, sadc_pkg::REG_CTRL, 32'h3, q);
				bus(1'b1, sadc_pkg::REG_CODE, 32'h2a5, q);
				bus(1'b0, sadc_pkg::REG_CTRL, 32'h0, q);
				check("ctrl", q, 32'h3);
				bus(1'b0, sadc_pkg::REG_CODE, 32'h0, q);
				check("code", q, 32'h2a5);
			end
			code <= (k == 4) ? ~code_tab[k] : code_tab[k];
			n = (k == 0) ? 10 : wlen(pc);
			sadc_host_model_inst.frame(cfg_tab[k], n, rx, lat, samp);
			check("first bit delay", 32'(lat >= 20 && lat <= 50), 32'h1);
			check("word", rx, expect_word(v, pc, n));
			if (n >= 10)
				check("sample window", samp, 32'h5);
			check("mux pos", mux_pos, {cfg_tab[k][5:4], cfg_tab[k][6]});
			check("mux com", mux_com, cfg_tab[k][7]);
			if (!cfg_tab[k][7])
				check("mux neg", mux_neg, {cfg_tab[k][5:4], ~cfg_tab[k][6]});
			check("oe_n after", dout_oe_n, 32'h1);
			pc = cfg_tab[k];
			v = code_tab[k] ^ (pc[3] ? 10'h000 : 10'h200);
			if (k == 4)
			begin
				bus(1'b0, sadc_pkg::REG_RESULT, 32'h0, q);
				check("result", q, {22'h0, v});
				bus(1'b0, sadc_pkg::REG_STATUS, 32'h0, q);
				check("status cfg", q[15:8], pc);
				check("status ready", q[2], 32'h1);
			end
		end
		// Link disabled: select falls go unanswered
		bus(1'b1, sadc_pkg::REG_CTRL, 32'h0, q);
		sadc_host_model_inst.frame(8'hbc, 10, rx, lat, samp);
		check("disabled", lat, 32'd80);
		results();
	end

	// Watchdog against a hung handshake
	initial
	begin
		repeat (40000) @(posedge clk);
		n_mismatch++;
		results();
	end
endmodule

// ===== tb/sadc_host_model.sv
// Host side model of the four-wire link: select, shift clock and config data
module sadc_host_model (
	input wire logic clk_i,
	input wire logic dout_i,
	input wire logic dout_oe_n_i,
	input wire logic sample_i,
	output logic cs_n_o,
	output logic sclk_o,
	output logic din_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Half of the 160 ns shift clock period, in 5 ns cycles
	localparam int HALF = 16;

	// Idle link: select high, shift clock still
	initial
	begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		din_o = 1'b0;
	end

	// ********************************************************
	// One exchange frame of n shift clocks
	// ********************************************************
	task automatic frame(input logic [7:0] cfg, input int n, output logic [15:0] rx,
		output int lat, output int samp);
		rx = 16'h0000;
		lat = 0;
		samp = 0;
		@(posedge clk_i);
		cs_n_o <= 1'b0;
		// no clocking until the port drives its output
		while (dout_oe_n_i !== 1'b0 && lat < 80)
		begin
			@(posedge clk_i);
			lat++;
		end
		for (int i = 0; i < n && lat < 80; i++)
		begin
			// launch on falling edge, capture on rising edge
			din_o <= (i < 8) ? cfg[7 - i] : 1'b1;
			repeat (HALF) @(posedge clk_i);
			rx = {rx[14:0], dout_i};
			samp += (sample_i === 1'b1);
			sclk_o <= 1'b1;
			repeat (HALF) @(posedge clk_i);
			sclk_o <= 1'b0;
		end
		repeat (HALF) @(posedge clk_i);
		cs_n_o <= 1'b1;
		// Released line shows no stale value
		din_o <= ~din_o;
		// select stays high for 50 conversion clocks, past the 44 of a conversion
		repeat (1000) @(posedge clk_i);
	endtask
endmodule
